// File: design/lpms_regs.svh
// Constants of the low-power mode sequencer
`ifndef LPMS_REGS_SVH
`define LPMS_REGS_SVH
`define LPMS_SEL_W 3
`define LPMS_SEL_EXT32K 3'h6
`define LPMS_SEL_RING 3'h3
`define LPMS_SEL_RST 3'h3
`define LPMS_PM_W 3
`define LPMS_PM_ACTIVE 3'h0
`define LPMS_PM_BACKUP 3'h4
`define LPMS_OSC_START_CYC 8'h20
`define LPMS_SWITCH_CYC 8'h08
`define LPMS_CNT_W 8
`define LPMS_NUM_RAM 8
`define LPMS_RET_MAP 16'hA4E4
`endif

// File: design/lpms_pkg.sv
// Types of the low-power mode sequencer
package lpms_pkg;
    typedef enum logic [4:0] {
        LPMS_ACTIVE = 5'h01,
        LPMS_SLEEP = 5'h02,
        LPMS_DEEP = 5'h04,
        LPMS_BACKUP = 5'h08,
        LPMS_STORAGE = 5'h10
    } lpms_mode_t;
endpackage

// File: design/lpms_sequencer.sv
// Power-mode sequencer: modes, clock gating, wake-up and retention
// Notes on behaviour
// - Ready flag rises after a 32-cycle start count once the enabled 32k oscillator runs.
// - Select value 6 picks the 32k oscillator; wait for ready.
// - Sequencer enable keeps the 32k oscillator on in all low modes.
// - Ring oscillator always runs and stays selectable.
// - Sleep wakes on enabled GPIO or peripheral interrupt or reset pin.
// - Deep/backup wake on RTC, GPIO, pin, serial, timers; storage fewer.
// - Sleep stops only the CPU clock.
// - Deep sleep gates CPU, bus and fast clocks; keeps CPU state.
// - Deep sleep keeps registers, RAM, pins; watchdogs off.
// - 32k oscillator stays on through deep sleep, backup and storage if enabled before.
// - Serial port and timers may run in deep sleep and backup.
// - Backup powers off core and fast oscillators; ring stays on.
// - Backup retains RAM blocks 1 to 7, each under its assigned enable.
// - RAM block 0 never retained across backup exit.
// - Power mode 4 enters backup, or storage if storage enabled; wake restarts at reset vector.
// - Sequencer registers keep contents through backup.
// - Storage like backup, no RAM, serial port and timers off.
// - Select change clears system ready; set again after switch.
`timescale 1ns/10ps
`include "lpms_regs.svh"
module lpms_sequencer (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic clk_en,
    // Oscillator controls
    input wire logic ext_32k_osc_power_down,
    input wire logic ext_32k_osc_enable,
    input wire logic ext_32k_osc_keep_lp,
    input wire logic [2:0] system_osc_select,
    output logic ext_32k_osc_run,
    output logic ext_32k_osc_ready,
    output logic system_clock_ready,
    output logic [2:0] system_oscillator,
    output logic ultra_low_power_ring_osc,
    // Mode requests
    input wire logic core_deep_select_bit,
    input wire logic core_wait,
    input wire logic [2:0] power_mode_field,
    input wire logic storage_enable,
    input wire logic [3:0] ram_keep_enable,
    // Wake sources
    input wire logic gpio_irq,
    input wire logic periph_irq,
    input wire logic rtc_irq,
    input wire logic external_reset_pin,
    input wire logic lp_serial_wake,
    input wire logic lp_timer_wake,
    input wire logic lp_serial_enable,
    input wire logic lp_timer_enable,
    // Gating and power controls
    output logic cpu_clock_en,
    output logic bus_clock_en,
    output logic always_on_clock_en,
    output logic fast_osc_en,
    output logic core_power_en,
    output logic watchdog_en,
    output logic gpio_hold,
    output logic dma_en,
    output logic lp_serial_run,
    output logic lp_timer_run,
    output logic [7:0] ram_retain,
    output logic boot_restart,
    output logic [4:0] mode_state
);
    lpms_pkg::lpms_mode_t mode, next_mode;
    logic [7:0] osc_cnt;
    logic [7:0] sw_cnt;
    logic [2:0] sel_q;
    logic osc_kept;

    // Enable index per RAM block, two bits each, block 0 lowest
    function automatic logic [1:0] lpms_ret_idx(input int blk);
        lpms_ret_idx = 2'(`LPMS_RET_MAP >> (2 * blk));
    endfunction

    // ----------------------------------------------------------------
    // Mode machine
    // ----------------------------------------------------------------
    wire sleep_wake = gpio_irq | periph_irq | external_reset_pin;
    wire lp_wake = rtc_irq | gpio_irq | external_reset_pin |
                   (lp_serial_enable & lp_serial_wake) |
                   (lp_timer_enable & lp_timer_wake);
    wire store_wake = rtc_irq | gpio_irq | external_reset_pin;
    wire backup_req = power_mode_field == `LPMS_PM_BACKUP;

    always_comb begin
        next_mode = mode;
        case (mode)
            lpms_pkg::LPMS_ACTIVE: begin
                if (backup_req) begin
                    next_mode = storage_enable ? lpms_pkg::LPMS_STORAGE
                                               : lpms_pkg::LPMS_BACKUP;
                end else if (core_wait) begin
                    next_mode = core_deep_select_bit ? lpms_pkg::LPMS_DEEP
                                                     : lpms_pkg::LPMS_SLEEP;
                end
            end
            lpms_pkg::LPMS_SLEEP: begin
                if (sleep_wake) begin
                    next_mode = lpms_pkg::LPMS_ACTIVE;
                end
            end
            lpms_pkg::LPMS_DEEP: begin
                if (lp_wake) begin
                    next_mode = lpms_pkg::LPMS_ACTIVE;
                end
            end
            lpms_pkg::LPMS_BACKUP: begin
                if (lp_wake) begin
                    next_mode = lpms_pkg::LPMS_ACTIVE;
                end
            end
            lpms_pkg::LPMS_STORAGE: begin
                if (store_wake) begin
                    next_mode = lpms_pkg::LPMS_ACTIVE;
                end
            end
            default: next_mode = lpms_pkg::LPMS_ACTIVE;
        endcase
    end

    wire in_active = mode == lpms_pkg::LPMS_ACTIVE;
    wire in_sleep = mode == lpms_pkg::LPMS_SLEEP;
    wire in_deep = mode == lpms_pkg::LPMS_DEEP;
    wire in_bk = mode == lpms_pkg::LPMS_BACKUP;
    wire in_st = mode == lpms_pkg::LPMS_STORAGE;
    wire gated = in_deep | in_bk | in_st;
    wire powered_off = in_bk | in_st;
    // Latch whether the 32k oscillator was on at low-power entry
    wire entering_lp = in_active & (next_mode != lpms_pkg::LPMS_ACTIVE);
    wire bk_exit = powered_off & in_active == 1'b0 &
                   next_mode == lpms_pkg::LPMS_ACTIVE;

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode <= lpms_pkg::LPMS_ACTIVE;
            osc_kept <= 1'b0;
            boot_restart <= 1'b0;
        end else if (clk_en) begin
            mode <= next_mode;
            boot_restart <= bk_exit;
            if (entering_lp) begin
                osc_kept <= ext_32k_osc_run;
            end
        end
    end

    // ----------------------------------------------------------------
    // 32k oscillator and system clock select
    // ----------------------------------------------------------------
    // Sequencer controls are never reset by a mode change
    wire sw_osc_on = ~ext_32k_osc_power_down & ext_32k_osc_enable;
    assign ext_32k_osc_run = gated ? (sw_osc_on | osc_kept |
                             ext_32k_osc_keep_lp)
                           : (sw_osc_on | (in_sleep & ext_32k_osc_keep_lp));
    // A new select restarts the count, so a clear beats a completion
    wire sel_changed = system_osc_select != sel_q;
    wire sel_osc_ok = system_osc_select != `LPMS_SEL_EXT32K |
                      ext_32k_osc_ready;

    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_cnt <= 8'h00;
            sw_cnt <= 8'h00;
            sel_q <= `LPMS_SEL_RST;
            ext_32k_osc_ready <= 1'b0;
            system_clock_ready <= 1'b1;
        end else if (clk_en) begin
            if (!ext_32k_osc_run) begin
                osc_cnt <= 8'h00;
                ext_32k_osc_ready <= 1'b0;
            end else if (osc_cnt == `LPMS_OSC_START_CYC) begin
                ext_32k_osc_ready <= 1'b1;
            end else begin
                osc_cnt <= osc_cnt + 8'h01;
            end
            sel_q <= system_osc_select;
            if (sel_changed) begin
                sw_cnt <= 8'h00;
                system_clock_ready <= 1'b0;
            end else if (!system_clock_ready && sel_osc_ok) begin
                if (sw_cnt == `LPMS_SWITCH_CYC) begin
                    system_clock_ready <= 1'b1;
                end else begin
                    sw_cnt <= sw_cnt + 8'h01;
                end
            end
        end
    end

    assign system_oscillator = sel_q;
    assign ultra_low_power_ring_osc = 1'b1;

    // ----------------------------------------------------------------
    // Gating, power and retention
    // ----------------------------------------------------------------
    assign cpu_clock_en = in_active;
    assign bus_clock_en = in_active | in_sleep;
    assign always_on_clock_en = ~powered_off;
    assign fast_osc_en = ~gated;
    assign core_power_en = ~powered_off;
    assign watchdog_en = ~gated;
    assign gpio_hold = gated;
    assign dma_en = in_active | in_sleep;
    assign lp_serial_run = lp_serial_enable & ~in_st;
    assign lp_timer_run = lp_timer_enable & ~in_st;

    genvar g;
    generate
        for (g = 0; g < `LPMS_NUM_RAM; g++) begin : g_ret
            if (g == 0) begin : g_zero
                assign ram_retain[g] = ~powered_off;
            end else begin : g_blk
                assign ram_retain[g] = in_bk ?
                    ram_keep_enable[lpms_ret_idx(g)] : ~in_st;
            end
        end
    endgenerate

    assign mode_state = mode;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sleep_cpu_a: assert property (@(posedge mclk) disable iff (srst)
        in_sleep |-> !cpu_clock_en && bus_clock_en && dma_en)
        else $error("sleep gating wrong");
    deep_gate_a: assert property (@(posedge mclk) disable iff (srst)
        in_deep |-> !bus_clock_en && !fast_osc_en && core_power_en)
        else $error("deep sleep gating wrong");
    ring_on_a: assert property (@(posedge mclk) disable iff (srst)
        ultra_low_power_ring_osc) else $error("ring oscillator off");
    ram0_drop_a: assert property (@(posedge mclk) disable iff (srst)
        powered_off |-> !ram_retain[0]) else $error("block 0 retained");
    storage_off_a: assert property (@(posedge mclk) disable iff (srst)
        in_st |-> ram_retain == 8'h00 && !lp_serial_run && !lp_timer_run)
        else $error("storage not cleared");
    sel_clear_a: assert property (@(posedge mclk) disable iff (srst)
        clk_en && sel_changed |=> !system_clock_ready)
        else $error("ready not cleared");
    sleep_wake_a: assert property (@(posedge mclk) disable iff (srst)
        clk_en && in_sleep && gpio_irq |=> in_active)
        else $error("sleep wake missed");
    store_wake_a: assert property (@(posedge mclk) disable iff (srst)
        in_st && !store_wake |=> !in_active)
        else $error("storage woke wrongly");
    keep_osc_a: assert property (@(posedge mclk) disable iff (srst)
        gated && ext_32k_osc_keep_lp |-> ext_32k_osc_run)
        else $error("32k dropped");
    restart_a: assert property (@(posedge mclk) disable iff (srst)
        clk_en && bk_exit |=> boot_restart && in_active)
        else $error("no restart");
    // Expectations below are written from the mode tables, not the logic
    deep_keep_a: assert property (@(posedge mclk) disable iff (srst)
        in_deep |-> !watchdog_en && gpio_hold && ram_retain == 8'hFF)
        else $error("deep sleep state not kept");
    bk_power_a: assert property (@(posedge mclk) disable iff (srst)
        in_bk |-> !core_power_en && !fast_osc_en && !always_on_clock_en)
        else $error("backup power not removed");
    st_power_a: assert property (@(posedge mclk) disable iff (srst)
        in_st |-> !core_power_en && !fast_osc_en && !always_on_clock_en)
        else $error("storage power not removed");
    // Map written out by hand so a wrong packed map is caught
    bk_retain_a: assert property (@(posedge mclk) disable iff (srst)
        in_bk |-> ram_retain[3:1] == ram_keep_enable[3:1] &&
            ram_retain[7:4] == {ram_keep_enable[2], ram_keep_enable[2],
            ram_keep_enable[1], ram_keep_enable[0]})
        else $error("backup retention wrong");
    osc_drop_a: assert property (@(posedge mclk) disable iff (srst)
        clk_en && !ext_32k_osc_run |=> !ext_32k_osc_ready)
        else $error("32k ready without run");
    osc_wait_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(ext_32k_osc_ready) |-> $past(osc_cnt) == `LPMS_OSC_START_CYC)
        else $error("32k ready too early");
    sel_hold_a: assert property (@(posedge mclk) disable iff (srst)
        clk_en && !system_clock_ready && !sel_osc_ok |=> !system_clock_ready)
        else $error("switch done before 32k ready");
    deep_wake_a: assert property (@(posedge mclk) disable iff (srst)
        clk_en && in_deep && rtc_irq |=> in_active)
        else $error("deep sleep wake missed");
    bk_stay_a: assert property (@(posedge mclk) disable iff (srst)
        in_bk && !lp_wake |=> in_bk)
        else $error("backup woke wrongly");
    restart_once_a: assert property (@(posedge mclk) disable iff (srst)
        clk_en && boot_restart |=> !boot_restart)
        else $error("restart pulse too long");
    sleep_osc_a: assert property (@(posedge mclk) disable iff (srst)
        in_sleep && ext_32k_osc_keep_lp |-> ext_32k_osc_run)
        else $error("32k dropped in sleep");
    sleep_ram_a: assert property (@(posedge mclk) disable iff (srst)
        in_sleep |-> ram_retain == 8'hFF && always_on_clock_en && fast_osc_en)
        else $error("sleep stopped more than the CPU");
    kept_osc_a: assert property (@(posedge mclk) disable iff (srst)
        gated && osc_kept |-> ext_32k_osc_run)
        else $error("32k not kept");
    lp_run_a: assert property (@(posedge mclk) disable iff (srst)
        (in_deep || in_bk) |-> lp_timer_run == lp_timer_enable &&
            lp_serial_run == lp_serial_enable)
        else $error("low-power peripherals stopped");
endmodule

// File: sim/tb_lpms_sequencer.sv
// Self-checking testbench of the low-power mode sequencer
`timescale 1ns/10ps
module tb_lpms_sequencer;
    // ---------------------------
    // Design ports
    // ---------------------------
    logic mclk = 1'b0, srst = 1'b1, clk_en = 1'b1, core_wait = 1'b0;
    logic ext_32k_osc_power_down = 1'b1, ext_32k_osc_enable = 1'b0;
    logic ext_32k_osc_keep_lp = 1'b0, core_deep_select_bit = 1'b0;
    logic storage_enable = 1'b0, gpio_irq = 1'b0, periph_irq = 1'b0;
    logic rtc_irq = 1'b0, external_reset_pin = 1'b0, lp_serial_wake = 1'b0;
    logic lp_timer_wake = 1'b0, lp_serial_enable = 1'b0;
    logic lp_timer_enable = 1'b0;
    logic [2:0] system_osc_select = 3'h3, power_mode_field = 3'h0;
    logic [3:0] ram_keep_enable = 4'h0;
    logic ext_32k_osc_run, ext_32k_osc_ready, system_clock_ready;
    logic ultra_low_power_ring_osc, cpu_clock_en, bus_clock_en, dma_en;
    logic always_on_clock_en, fast_osc_en, core_power_en, watchdog_en;
    logic gpio_hold, lp_serial_run, lp_timer_run, boot_restart;
    logic [2:0] system_oscillator;
    logic [7:0] ram_retain;
    logic [4:0] mode_state;
    int fail_count = 0, comparisons = 0, cycles = 0, i;
    logic [15:0] seed = 16'h3C1D;
    logic seen;
    lpms_sequencer lpms_sequencer_i (.mclk, .srst, .clk_en,
        .ext_32k_osc_power_down, .ext_32k_osc_enable, .ext_32k_osc_keep_lp,
        .system_osc_select, .ext_32k_osc_run, .ext_32k_osc_ready,
        .system_clock_ready, .system_oscillator, .ultra_low_power_ring_osc,
        .core_deep_select_bit, .core_wait, .power_mode_field, .storage_enable,
        .ram_keep_enable, .gpio_irq, .periph_irq, .rtc_irq,
        .external_reset_pin,
        .lp_serial_wake, .lp_timer_wake, .lp_serial_enable, .lp_timer_enable,
        .cpu_clock_en, .bus_clock_en, .always_on_clock_en, .fast_osc_en,
        .core_power_en, .watchdog_en, .gpio_hold, .dma_en, .lp_serial_run,
        .lp_timer_run, .ram_retain, .boot_restart, .mode_state);
    // ---------------------------
    // Helpers
    // ---------------------------
    always #12.5 mclk = ~mclk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Block 0 is never kept; blocks 4..7 reuse enables a, b, c, c
    function automatic logic [7:0] exp_ret(input logic [3:0] e,
                                           input logic st);
        exp_ret = st ? 8'h00
                     : {e[2], e[2], e[1], e[0], e[3], e[2], e[1], 1'b0};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic sel(input logic [2:0] v);
        int n;
        @(posedge mclk);
        system_osc_select <= v;
        @(posedge mclk);
        #1;
        chk("sysready drop", 8'h00, 8'(system_clock_ready));
        for (n = 0; n < 40 && system_clock_ready !== 1'b1; n++) begin
            @(posedge mclk);
        end
        #1;
        chk("sysready", 8'h01, 8'(system_clock_ready));
        chk("sysosc", 8'(v), 8'(system_oscillator));
    endtask
    // When bk is set the power mode request is driven and core wait stays low; the deep select bit still follows dsel
    // Wake sources idle at each entry
    task automatic enter(input logic dsel, input logic bk);
        @(posedge mclk);
        core_deep_select_bit <= dsel;
        core_wait <= !bk;
        power_mode_field <= bk ? 3'h4 : 3'h0;
        @(posedge mclk);
        core_wait <= 1'b0;
        power_mode_field <= 3'h0;
        #1;
    endtask
    task automatic wake(input logic [5:0] src);
        @(posedge mclk);
        {gpio_irq, periph_irq, rtc_irq, external_reset_pin, lp_serial_wake,
            lp_timer_wake} <= src;
        @(posedge mclk);
        {gpio_irq, periph_irq, rtc_irq, external_reset_pin, lp_serial_wake,
            lp_timer_wake} <= 6'h00;
        #1;
        seen = boot_restart;
        @(posedge mclk);
        #1;
        seen = seen | boot_restart;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ---------------------------
    // Main sequence
    // ---------------------------
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk("mode", 8'h01, 8'(mode_state));
        chk("ready32k", 8'h00, 8'(ext_32k_osc_ready));
        chk("sysready", 8'h01, 8'(system_clock_ready));
        chk("ring", 8'h01, 8'(ultra_low_power_ring_osc));
        @(posedge mclk);
        ext_32k_osc_enable <= 1'b1;
        ext_32k_osc_keep_lp <= 1'b1;
        @(posedge mclk);
        #1;
        chk("run powered down", 8'h00, 8'(ext_32k_osc_run));
        @(posedge mclk);
        ext_32k_osc_power_down <= 1'b0;
        for (i = 0; i < 60 && ext_32k_osc_ready !== 1'b1; i++) @(posedge mclk);
        #1;
        chk("ready32k", 8'h01, 8'(ext_32k_osc_ready));
        sel(3'h6);
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            enter(1'b0, 1'b0);
            chk("sleep", 8'h02, 8'(mode_state));
            chk("sleep clocks", 8'h03, {5'h00, cpu_clock_en, bus_clock_en,
                dma_en & always_on_clock_en & ext_32k_osc_run});
            wake(i == 0 ? 6'h20 : (seed[0] ? 6'h10 : 6'h04));
            chk("sleep wake", 8'h01, 8'(mode_state));
        end
        enter(1'b1, 1'b0);
        chk("deep", 8'h04, 8'(mode_state));
        chk("deep gates", 8'h03, {2'h0, cpu_clock_en, bus_clock_en,
            fast_osc_en, watchdog_en, gpio_hold,
            ext_32k_osc_run});
        wake(6'h10);
        chk("deep ignore", 8'h04, 8'(mode_state));
        wake(6'h08);
        chk("deep wake", 8'h01, 8'(mode_state));
        chk("deep no restart", 8'h00, 8'(seen));
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            ram_keep_enable <= seed[3:0];
            lp_timer_enable <= seed[4];
            enter(1'b0, 1'b1);
            chk("backup", 8'h08, 8'(mode_state));
            chk("retain", exp_ret(seed[3:0], 1'b0), ram_retain);
            chk("timer run", 8'(seed[4]), 8'(lp_timer_run));
            chk("bk power", 8'h03, {3'h0, core_power_en, fast_osc_en,
                always_on_clock_en, ext_32k_osc_run,
                ultra_low_power_ring_osc});
            wake(seed[4] ? 6'h01 : 6'h20);
            chk("bk wake", 8'h01, 8'(mode_state));
            chk("restart", 8'h01, 8'(seen));
        end
        storage_enable <= 1'b1;
        lp_serial_enable <= 1'b1;
        enter(1'b0, 1'b1);
        chk("storage", 8'h10, 8'(mode_state));
        chk("st retain", 8'h00, ram_retain);
        chk("st lp run", 8'h00, 8'({lp_serial_run, lp_timer_run}));
        wake(6'h02);
        chk("st ignore", 8'h10, 8'(mode_state));
        wake(6'h04);
        chk("st wake", 8'h01, 8'(mode_state));
        sel(3'h3);
        give_verdict();
    end
endmodule
